// ### hdl/rdseq_pkg.sv
package rdseq_pkg;

  // ****************************************************************
  // Reset vector and widths
  // ****************************************************************
  localparam int          PC_W         = 12;
  localparam logic [11:0] RESET_VECTOR = 12'hFFF;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam longint CLK_HZ        = 25000000;
  // Delay times in microseconds
  localparam longint DLY_US_10     = 250;
  localparam longint DLY_US_11     = 18000;
  localparam longint DLY_US_00     = 60000;
  localparam longint DLY_US_01     = 1000000;
  localparam longint US_PER_S      = 1000000;
  localparam int     CNT_W         = 25;
  // Cycle counts, rounded down (timeouts are nominal figures)
  localparam logic [24:0] CYC_10 = 25'(DLY_US_10 * CLK_HZ / US_PER_S);
  localparam logic [24:0] CYC_11 = 25'(DLY_US_11 * CLK_HZ / US_PER_S);
  localparam logic [24:0] CYC_00 = 25'(DLY_US_00 * CLK_HZ / US_PER_S);
  localparam logic [24:0] CYC_01 = 25'(DLY_US_01 * CLK_HZ / US_PER_S);

  // ****************************************************************
  // Fuse encodings
  // ****************************************************************
  localparam logic [1:0] DLY_SEL_250US = 2'h2;
  localparam logic [1:0] DLY_SEL_18MS  = 2'h3;
  localparam logic [1:0] DLY_SEL_60MS  = 2'h0;
  localparam logic [1:0] DLY_SEL_1S    = 2'h1;

  // Reset source bundle
  typedef struct packed {
    logic power_on;
    logic brownout;
    logic watchdog;
    logic pin_low;
  } rdseq_src_t;

  // Sequencer states
  typedef enum logic [1:0] {
    ST_HOLD  = 2'b00,
    ST_COUNT = 2'b01,
    ST_RUN   = 2'b10,
    ST_SLEEP = 2'b11
  } rdseq_state_t;

endpackage

// ### hdl/rdseq_timer.sv
`timescale 1ns/10ps
module rdseq_timer #(
  parameter int W = 25
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Control
  input  wire logic         run_i,
  input  wire logic [W-1:0] limit_i,
  // Status
  output logic              done_o
);

  logic [W-1:0] cnt_q;

  // Counter clears whenever run drops, so a restart begins at zero
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= '0;
    end else if (!run_i) begin
      cnt_q <= '0;
    end else if (!done_o) begin
      cnt_q <= cnt_q + W'(1);
    end
  end

  // Done once the count reaches the limit
  assign done_o = run_i && (cnt_q >= limit_i);

endmodule

// ### hdl/rdseq_core.sv
`timescale 1ns/10ps
// What this block does
// - Any reset source reinitializes and restarts at top
// - Program counter loads reset vector 0FFF
// - Power-up sets latch; reset held while set
// - Delay timer waits for external pin high
// - Timeout end clears latch, releases reset
// - Two-bit fuse selects delay timeout period
// - Same delay times wake-up from power-down
// - Brown-out holds reset until supply recovers
// - Two fuse bits choose brown-out threshold
// - Power-on detector holds reset while supply rises
module rdseq_core #(
  parameter int CNT_W = rdseq_pkg::CNT_W,
  parameter logic [CNT_W-1:0] CYC_10 = rdseq_pkg::CYC_10,
  parameter logic [CNT_W-1:0] CYC_11 = rdseq_pkg::CYC_11,
  parameter logic [CNT_W-1:0] CYC_00 = rdseq_pkg::CYC_00,
  parameter logic [CNT_W-1:0] CYC_01 = rdseq_pkg::CYC_01
) (
  // Clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  // Reset sources
  input  wire logic                     power_on_i,
  input  wire logic                     external_reset_n_i,
  input  wire logic                     watchdog_i,
  // Brown-out comparators, one per level: high means supply below level
  input  wire logic [2:0]               brownout_below_i,
  // Configuration fuses
  input  wire logic [1:0]               delay_sel_i,
  input  wire logic [1:0]               brownout_level_sel_i,
  // Power-down control from the core
  input  wire logic                     sleep_i,
  // Outputs
  output logic                          reset_o,
  output logic                          wakeup_o,
  output logic                          pc_load_o,
  output logic [rdseq_pkg::PC_W-1:0]    pc_vector_o,
  output logic                          latch_o
);

  // ****************************************************************
  // Helpers
  // ****************************************************************

  // Fuse code to delay in cycles
  function automatic logic [CNT_W-1:0] delay_cycles(input logic [1:0] s);
    logic [CNT_W-1:0] r;
    r = CYC_11;
    if (s == rdseq_pkg::DLY_SEL_250US) begin
      r = CYC_10;
    end else if (s == rdseq_pkg::DLY_SEL_60MS) begin
      r = CYC_00;
    end else if (s == rdseq_pkg::DLY_SEL_1S) begin
      r = CYC_01;
    end
    return r;
  endfunction

  // ****************************************************************
  // Source merge
  // ****************************************************************
  rdseq_pkg::rdseq_src_t src;
  rdseq_pkg::rdseq_state_t state_q;
  rdseq_pkg::rdseq_state_t state_d;
  logic                    brownout;
  logic                    any_src;
  logic                    timer_run;
  logic                    timer_done;
  logic                    latch_q;
  logic                    any_src_q;

  // Level codes: 00 low (2.2 V), 01 mid (2.4 V), 1x high (4.1 V)
  always_comb begin
    brownout = brownout_below_i[0];
    if (brownout_level_sel_i[1]) begin
      brownout = brownout_below_i[2];
    end else if (brownout_level_sel_i[0]) begin
      brownout = brownout_below_i[1];
    end
  end

  // Bundle the sources; a low pin is itself a reset
  always_comb begin
    src.power_on = power_on_i;
    src.brownout = brownout;
    src.watchdog = watchdog_i;
    src.pin_low  = !external_reset_n_i;
  end

  assign any_src = |src;

  // ****************************************************************
  // Delay reset timer
  // ****************************************************************
  // Timer runs while counting to release or sleeping; the shared
  // counter means sleep and release use identical periods.
  // The counter clears on every leave of these states, so a
  // restart after a pin glitch always begins from zero.
  // Limitation: the period follows the fuse live, so a fuse
  // change mid-count takes effect at once.
  assign timer_run = (state_q == rdseq_pkg::ST_COUNT) ||
                     (state_q == rdseq_pkg::ST_SLEEP);

  rdseq_timer #(
    .W (CNT_W)
  ) u_delay_reset_timer (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .run_i   (timer_run),
    .limit_i (delay_cycles(delay_sel_i)),
    .done_o  (timer_done)
  );

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_comb begin
    state_d = state_q;
    case (state_q)
      rdseq_pkg::ST_HOLD: begin
        // Wait for every source to clear, pin high included
        if (!any_src) begin
          state_d = rdseq_pkg::ST_COUNT;
        end
      end
      rdseq_pkg::ST_COUNT: begin
        if (any_src) begin
          state_d = rdseq_pkg::ST_HOLD;
        end else if (timer_done) begin
          state_d = rdseq_pkg::ST_RUN;
        end
      end
      rdseq_pkg::ST_RUN: begin
        if (any_src) begin
          state_d = rdseq_pkg::ST_HOLD;
        end else if (sleep_i) begin
          state_d = rdseq_pkg::ST_SLEEP;
        end
      end
      rdseq_pkg::ST_SLEEP: begin
        if (any_src) begin
          state_d = rdseq_pkg::ST_HOLD;
        end else if (timer_done) begin
          state_d = rdseq_pkg::ST_RUN;
        end
      end
      default: begin
        state_d = rdseq_pkg::ST_HOLD;
      end
    endcase
  end

  // Reset starts in hold: the latch is set at power-up
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= rdseq_pkg::ST_HOLD;
    end else begin
      state_q <= state_d;
    end
  end

  // Reset latch: set by any source, cleared only at timeout.
  // A source and a timeout in the same cycle keep the latch set,
  // so a late glitch can never slip through as a release.
  // Sleep never clears the latch: a wake-up is not a release.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      latch_q <= 1'b1;
    end else if (any_src) begin
      latch_q <= 1'b1;
    end else if (state_q == rdseq_pkg::ST_COUNT && timer_done) begin
      latch_q <= 1'b0;
    end
  end

  // Remember a source seen in the previous cycle so the vector load follows
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      any_src_q <= 1'b0;
    end else begin
      any_src_q <= any_src;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Reset held while the latch is set; sources act at once too
  assign reset_o  = latch_q || any_src;
  assign latch_o  = latch_q;
  // One-cycle pulse as sleep ends by timeout
  assign wakeup_o = (state_q == rdseq_pkg::ST_SLEEP) && timer_done &&
                    !any_src;

  // Vector stays on the PC bus; load asserted through reset
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pc_load_o   <= 1'b1;
      pc_vector_o <= rdseq_pkg::RESET_VECTOR;
    end else begin
      pc_load_o   <= latch_q || any_src || any_src_q;
      pc_vector_o <= rdseq_pkg::RESET_VECTOR;
    end
  end

endmodule

// ### dv/rdseq_supply_model.sv
`timescale 1ns/10ps
// ****
// Supply rail and reset pin outside the device
// ****
module rdseq_supply_model (
  // From the bench
  input  wire logic [1:0] sag_i,
  input  wire logic       ramp_i,
  input  wire logic       pin_low_i,
  // Toward the sequencer
  output logic            power_on_o,
  output logic            pin_n_o,
  output logic [2:0]      below_o
);
  // Pin has a pull-up, so a released pin reads high
  assign pin_n_o    = ~pin_low_i;
  assign power_on_o = ramp_i;
  // Nested levels: a deep sag trips every higher comparator too
  assign below_o = {sag_i >= 2'h1, sag_i >= 2'h2, sag_i == 2'h3};
endmodule

// ### dv/rdseq_checker.sv
`timescale 1ns/10ps
// ****
// Sequencer checker
// ****
module rdseq_checker #(
  parameter int               CNT_W  = 25,
  parameter logic [CNT_W-1:0] CYC_10 = 4,
  parameter logic [CNT_W-1:0] CYC_11 = 8,
  parameter logic [CNT_W-1:0] CYC_00 = 12,
  parameter logic [CNT_W-1:0] CYC_01 = 16
) (
  // Inputs
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        power_on_i,
  input wire logic        external_reset_n_i,
  input wire logic        watchdog_i,
  input wire logic [2:0]  brownout_below_i,
  input wire logic [1:0]  delay_sel_i,
  input wire logic [1:0]  brownout_level_sel_i,
  input wire logic        sleep_i,
  // Outputs
  input wire logic        reset_o,
  input wire logic        wakeup_o,
  input wire logic        pc_load_o,
  input wire logic [11:0] pc_vector_o,
  input wire logic        latch_o
);
  logic       bo;
  logic       src;
  logic [5:0] lim;
  logic [5:0] quiet_q;
  // Only the fuse-selected brown-out level may trip
  assign bo  = brownout_level_sel_i[1] ? brownout_below_i[2]
             : brownout_below_i[brownout_level_sel_i[0]];
  assign src = power_on_i | watchdog_i | ~external_reset_n_i | bo;
  assign lim = 6'(delay_sel_i == 2'h2 ? CYC_10 : delay_sel_i == 2'h3
             ? CYC_11 : delay_sel_i == 2'h0 ? CYC_00 : CYC_01);
  // Edges without any source; saturates so it never wraps
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) quiet_q <= 6'h0;
    else if (src) quiet_q <= 6'h0;
    else if (quiet_q != 6'h3F) quiet_q <= quiet_q + 6'h1;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_pulse;
    wakeup_o ##1 !wakeup_o;
  endsequence
  a_vector_fixed: assert property (pc_vector_o == 12'hFFF)
    else $error("pc vector wrong");
  a_source_resets: assert property (src |-> reset_o)
    else $error("source without reset");
  a_source_latches: assert property (src |=> latch_o)
    else $error("source did not set latch");
  a_latch_holds: assert property (latch_o |-> reset_o)
    else $error("latch set, reset low");
  a_pc_loads: assert property (reset_o |=> pc_load_o)
    else $error("pc not loaded");
  a_clear_early: assert property ($fell(latch_o) |-> quiet_q >= lim)
    else $error("latch cleared early");
  a_clear_late: assert property (quiet_q == lim + 6'h5 |-> !latch_o)
    else $error("latch cleared late");
  a_wake_pulse: assert property (wakeup_o |-> s_pulse)
    else $error("wake not one cycle");
endmodule
bind rdseq_core rdseq_checker #(.CNT_W(CNT_W), .CYC_10(CYC_10),
  .CYC_11(CYC_11), .CYC_00(CYC_00), .CYC_01(CYC_01)) chk_u (.*);

// ### dv/reset_delay_sequencer_tb.sv
`timescale 1ns/10ps
// ****
// Sequencer bench
// ****
module reset_delay_sequencer_tb;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wdog, slp, ramp, pin_low, por, pin_n;
  logic        rst_o, wake, pcl, latch, hit;
  logic [1:0]  dsel, lsel, sag;
  logic [2:0]  below;
  logic [11:0] vec;
  int          err_count = 0;
  int          comparisons = 0;
  int          n;

  // Clock at 25 MHz
  always #20 clk_i = ~clk_i;

  rdseq_supply_model sup_u (.sag_i(sag), .ramp_i(ramp),
    .pin_low_i(pin_low), .power_on_o(por), .pin_n_o(pin_n),
    .below_o(below));
  // Short delays keep the run brief
  rdseq_core #(.CYC_10(25'h4), .CYC_11(25'h8), .CYC_00(25'hC),
    .CYC_01(25'h10)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
    .power_on_i(por), .external_reset_n_i(pin_n), .watchdog_i(wdog),
    .brownout_below_i(below), .delay_sel_i(dsel),
    .brownout_level_sel_i(lsel), .sleep_i(slp), .reset_o(rst_o),
    .wakeup_o(wake), .pc_load_o(pcl), .pc_vector_o(vec),
    .latch_o(latch));

  task automatic results;
    if (err_count == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [11:0] e, input logic [11:0] a);
    comparisons++;
    if (a !== e) begin
      err_count++;
      $display("[FAIL] %0t exp %h got %h", $time, e, a);
    end
  endtask
  // Delays are nominal, so a few edges of pipeline are allowed
  task automatic chk_cyc(input int e, input int a);
    comparisons++;
    if (a < e || a > e + 4) begin
      err_count++;
      $display("[FAIL] %0t exp %h got %h", $time, e, a);
    end
    if (a >= 200) results;
  endtask
  task automatic step;
    @(posedge clk_i);
    #1;
  endtask
  function automatic int dly(input logic [1:0] s);
    return s == 2'h2 ? 4 : s == 2'h3 ? 8 : s == 2'h0 ? 12 : 16;
  endfunction

  // Each pass: raise one source, then pull the pin low too, release, time latch and wake-up
  initial begin
    n = $urandom(66);
    {wdog, slp, dsel, lsel, sag} = '0;
    ramp = 1'b1;
    pin_low = 1'b1;
    repeat (20) @(posedge clk_i);
    #1 rst_i = 1'b0;
    for (int k = 0; k < 12; k++) begin
      dsel = k < 4 ? 2'(k) : 2'($urandom);
      lsel = 2'($urandom % 3);
      case (k % 4)
        0: ramp = 1'b1;
        1: pin_low = 1'b1;
        2: wdog = 1'b1;
        default: sag = 2'($urandom);
      endcase
      hit = k % 4 != 3 || sag >= (lsel[1] ? 1 : lsel[0] ? 2 : 3);
      #1 chk(12'(hit), 12'(rst_o));
      pin_low = 1'b1;
      step;
      chk(12'h1, 12'(latch));
      chk(12'h1, 12'(pcl));
      chk(12'hFFF, vec);
      {ramp, wdog, sag, pin_low} = '0;
      // Late pin glitch: a timer that kept counting would end early
      if (k % 2 == 1) begin
        repeat (dly(dsel) - 1) step;
        pin_low = 1'b1;
        step;
        pin_low = 1'b0;
      end
      for (n = 0; latch === 1'b1 && n < 200; n++) step;
      chk_cyc(dly(dsel), n);
      slp = 1'b1;
      for (n = 0; wake !== 1'b1 && n < 200; n++) step;
      slp = 1'b0;
      chk_cyc(dly(dsel), n);
      // Once released, reset and the vector load must both be low
      chk(12'h0, 12'(rst_o));
      chk(12'h0, 12'(pcl));
    end
    results;
  end
endmodule
